// ### hdl/dsl_regs.vh
// constants for the serial converter load port with chain output
// assumes plain verilog-2005 includers; definitions only
//
// Functional notes
// - select low: shift data in on each rising link clock, msb first, 16 bits
// - select rising edge copies shift register bits 11 to 2 into the code register
// - select high: link clock edges ignored, no bits accepted
// - reset clears the code register to zero before any write
// - a bit reaches the chain output after 16 falling link clock edges
// - chain output shows each input bit 15 cycles plus the clock high time after its rising edge
// - chain output changes only on falling link clock edges while select low
// - select high: chain output stays driven at the last shifted bit
`ifndef DSL_REGS_VH
`define DSL_REGS_VH
`define DSL_SHIFT_W   16
`define DSL_CODE_W    10
`define DSL_CODE_LSB  2
`define DSL_CODE_RST  10'h000
`define DSL_BUF_DEPTH 2
`endif

// ### hdl/dsl_buf2.v
// two-entry buffer for converter codes on the way to the user side
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module dsl_buf2 #(
    parameter W = 10
) (
    input  wire         clk_sys,
    input  wire         rst,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    output wire [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready
);
    reg [W-1:0] mem [0:1];
    reg         wr_ptr;
    reg         rd_ptr;
    reg [1:0]   count;
    wire        do_wr;
    wire        do_rd;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];
    assign do_wr     = in_valid & in_ready;
    assign do_rd     = out_valid & out_ready;

    always @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (do_wr) begin
                wr_ptr <= ~wr_ptr;
            end
            if (do_rd) begin
                rd_ptr <= ~rd_ptr;
            end
            if (do_wr & ~do_rd) begin
                count <= count + 2'h1;
            end else if (do_rd & ~do_wr) begin
                count <= count - 2'h1;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// ### hdl/dsl_load_port.v
// serial load port: shift register, code register and chain output
// assumes link pins are asynchronous to clk_sys and the link clock is far slower
`timescale 1ns/10ps
`include "dsl_regs.vh"
module dsl_load_port #(
    parameter SHIFT_W  = `DSL_SHIFT_W,
    parameter CODE_LSB = `DSL_CODE_LSB
) (
    input  wire                   clk_sys,
    input  wire                   rst,
    input  wire                   sdata_in,
    input  wire                   link_clk,
    input  wire                   sel_n,
    output reg                    chain_out,
    output wire                   chain_oe,
    output reg  [`DSL_CODE_W-1:0] dac_code,
    output wire [`DSL_CODE_W-1:0] code_data,
    output wire                   code_valid,
    input  wire                   code_ready,
    output reg                    code_lost
);
    // ------------------------------------------------------------
    // local constants
    // ------------------------------------------------------------
    localparam       CODE_W      = `DSL_CODE_W;
    localparam       STROBE_N    = 2;
    localparam       STROBE_CLK  = 0;
    localparam       STROBE_SEL  = 1;
    // idle levels: link clock low, select high
    localparam [1:0] STROBE_IDLE = 2'h2;

    // ------------------------------------------------------------
    // data pin synchroniser
    // ------------------------------------------------------------
    reg data_s1;
    reg data_s2;

    always @(posedge clk_sys) begin
        if (rst) begin
            data_s1 <= 1'b0;
            data_s2 <= 1'b0;
        end else begin
            data_s1 <= sdata_in;
            data_s2 <= data_s1;
        end
    end

    // ------------------------------------------------------------
    // strobe pin synchronisers and edge detectors
    // ------------------------------------------------------------
    wire [STROBE_N-1:0] strobe_raw;
    wire [STROBE_N-1:0] strobe_sync;
    wire [STROBE_N-1:0] strobe_last;

    assign strobe_raw[STROBE_CLK] = link_clk;
    assign strobe_raw[STROBE_SEL] = sel_n;

    genvar p;
    generate
        for (p = 0; p < STROBE_N; p = p + 1) begin : g_strobe
            reg stage1;
            reg stage2;
            reg last;

            // reset to the idle level so that no false edge follows reset
            always @(posedge clk_sys) begin
                if (rst) begin
                    stage1 <= STROBE_IDLE[p];
                    stage2 <= STROBE_IDLE[p];
                    last   <= STROBE_IDLE[p];
                end else begin
                    stage1 <= strobe_raw[p];
                    stage2 <= stage1;
                    last   <= stage2;
                end
            end

            assign strobe_sync[p] = stage2;
            assign strobe_last[p] = last;
        end
    endgenerate

    wire clk_rise;
    wire clk_fall;
    wire sel_rise;
    wire sel_low;

    assign clk_rise = strobe_sync[STROBE_CLK] & ~strobe_last[STROBE_CLK];
    assign clk_fall = ~strobe_sync[STROBE_CLK] & strobe_last[STROBE_CLK];
    assign sel_rise = strobe_sync[STROBE_SEL] & ~strobe_last[STROBE_SEL];
    assign sel_low  = ~strobe_sync[STROBE_SEL];

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    reg  [SHIFT_W-1:0] shift;
    wire [SHIFT_W-1:0] next_shift;
    wire               shift_en;

    assign shift_en = clk_rise & sel_low;

    genvar b;
    generate
        for (b = 0; b < SHIFT_W; b = b + 1) begin : g_bit
            if (b == 0) begin : g_lsb
                assign next_shift[b] = shift_en ? data_s2 : shift[b];
            end else begin : g_upper
                assign next_shift[b] = shift_en ? shift[b-1] : shift[b];
            end
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (rst) begin
            shift <= {SHIFT_W{1'b0}};
        end else begin
            shift <= next_shift;
        end
    end

    // ------------------------------------------------------------
    // chain output
    // ------------------------------------------------------------
    reg next_chain;

    // msb leaves on the falling edge after its 16th rising edge
    always @* begin
        next_chain = chain_out;
        if (clk_fall & sel_low) begin
            next_chain = shift[SHIFT_W-1];
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            chain_out <= 1'b0;
        end else begin
            chain_out <= next_chain;
        end
    end

    // pin is never released, it holds the last bit while select is high
    assign chain_oe = 1'b1;

    // ------------------------------------------------------------
    // code register, loaded on select rising edge
    // ------------------------------------------------------------
    wire [CODE_W-1:0] new_code;
    wire              buf_ready;
    reg  [CODE_W-1:0] next_dac_code;
    reg               next_code_lost;

    // dummy bits above and sub-lsb bits below the code are dropped
    assign new_code = shift[CODE_LSB+CODE_W-1:CODE_LSB];

    always @* begin
        next_dac_code  = dac_code;
        next_code_lost = 1'b0;
        if (sel_rise) begin
            next_dac_code  = new_code;
            next_code_lost = ~buf_ready;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            dac_code  <= `DSL_CODE_RST;
            code_lost <= 1'b0;
        end else begin
            dac_code  <= next_dac_code;
            code_lost <= next_code_lost;
        end
    end

    // ------------------------------------------------------------
    // code stream buffer toward the user side
    // ------------------------------------------------------------
    // a full buffer drops the new code but the code register still loads
    dsl_buf2 #(
        .W (CODE_W)
    ) u_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_data   (new_code),
        .in_valid  (sel_rise),
        .in_ready  (buf_ready),
        .out_data  (code_data),
        .out_valid (code_valid),
        .out_ready (code_ready)
    );
endmodule

// ### test/dsl_load_port_monitor.sv
// checker bound to the load port top; sees its pins only
// assumes 3 to 4 clk_sys from a pin edge to its effect
`timescale 1ns/10ps
module dsl_load_port_monitor (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       link_clk,
    input wire logic       sel_n,
    input wire logic       chain_out,
    input wire logic       chain_oe,
    input wire logic       code_valid,
    input wire logic       code_lost,
    input wire logic [9:0] dac_code
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_oe; chain_oe; endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_ch; sel_n [*8] |-> $stable(chain_out); endproperty
    a_ch: assert property (p_ch) else $error("chain");
    property p_fa; $changed(chain_out) |-> !$past(link_clk,2); endproperty
    a_fa: assert property (p_fa) else $error("fall");
    property p_ld; $changed(dac_code) |-> $past(sel_n) && !$past(sel_n,8); endproperty
    a_ld: assert property (p_ld) else $error("load");
    property p_id; sel_n [*8] |-> $stable(dac_code); endproperty
    a_id: assert property (p_id) else $error("idle");
    property p_vd; $rose(sel_n) && !code_valid |-> ##[2:6] code_valid; endproperty
    a_vd: assert property (p_vd) else $error("valid");
    property p_ls; code_lost |-> code_valid ##1 !code_lost; endproperty
    a_ls: assert property (p_ls) else $error("lost");
    property p_rs; $fell(rst) |-> !code_valid && dac_code == 10'h000; endproperty
    a_rs: assert property (p_rs) else $error("reset");
endmodule
bind dsl_load_port dsl_load_port_monitor u_mon (.clk_sys, .rst, .link_clk, .sel_n,
    .chain_out, .chain_oe, .code_valid, .code_lost, .dac_code);

// ### test/dsl_host_model.sv
// host model of the link pins: select, 200 ns link clock, data msb first
// assumes send is called at or just past a clk_sys edge
`timescale 1ns/10ps
module dsl_host_model (
    input  wire logic clk_sys,
    output logic      link_clk = 0, sel_n = 1, sdata_in = 0
);
    task send(input logic [31:0] w, input int n, hold);
        @(posedge clk_sys) sel_n <= hold;
        for (int i = n - 1; i >= 0; i--) begin
            sdata_in <= w[i];
            repeat (4) @(posedge clk_sys);
            link_clk <= 1;
            repeat (4) @(posedge clk_sys);
            link_clk <= 0;
        end
        repeat (4) @(posedge clk_sys);
        sel_n <= 1;
        sdata_in <= ~sdata_in;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule

// ### test/test_dsl_load_port.sv
// bench of the load port: link frames, chain delay, code buffer
// assumes dsl_host_model drives the link pins
`timescale 1ns/10ps
module test_dsl_load_port;
    logic        clk_sys = 0, rst = 1, code_ready = 0;
    logic [15:0] lost = 0;
    wire         link_clk, sel_n, sdata_in, chain_out, chain_oe, code_valid, code_lost;
    wire  [9:0]  dac_code, code_data, code_next;
    int          bad_count = 0, compares = 0;
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) lost <= lost + code_lost;
    dsl_host_model host (.clk_sys, .link_clk, .sel_n, .sdata_in);
    dsl_load_port dut (.clk_sys, .rst, .sdata_in, .link_clk, .sel_n, .chain_out,
        .chain_oe, .dac_code, .code_data, .code_valid, .code_ready, .code_lost);
    dsl_load_port dut_next (.clk_sys, .rst, .sdata_in(chain_out), .link_clk, .sel_n,
        .chain_out(), .chain_oe(), .dac_code(code_next), .code_data(), .code_valid(),
        .code_ready, .code_lost());
    task chk(input logic [15:0] s, e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %0t %h %h", $time, s, e);
        end
    endtask
    task report_and_stop;
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task frame(input logic [31:0] w, input int n, hold, input logic [10:0] e);
        host.send(w, n, hold);
        #1 chk({chain_out, dac_code}, e);
    endtask
    task pop(input logic [9:0] c);
        @(posedge clk_sys) code_ready <= 1;
        #1 chk({code_valid, code_data}, {1'b1, c});
        @(posedge clk_sys) code_ready <= 0;
    endtask
    task sc_frames;
        repeat (20) @(posedge clk_sys);
        rst <= 0;
        #1 chk({chain_oe, chain_out, code_valid, dac_code}, 16'h1000);
        frame(32'h0FFC, 12, 0, 11'h3FF);
        frame(32'hF554, 16, 0, 11'h555);
        frame(32'h08000, 17, 0, 11'h400);
        frame(0, 16, 1, 11'h400);
        chk(lost, 1);
    endtask
    task sc_drain;
        pop(10'h3FF);
        pop(10'h155);
        #1 chk(code_valid, 0);
        frame(32'h7FFF, 16, 0, 11'h3FF);
        frame(32'h0ABC0248, 32, 0, 11'h092);
        chk(code_next, 10'h2AF);
    endtask
    initial begin
        sc_frames;
        sc_drain;
        report_and_stop;
    end
    initial begin
        #60us;
        bad_count++;
        report_and_stop;
    end
endmodule
